// ===== logic/fbh_host.sv
// Host controller for a two-bank asynchronous flash: APB registers in,
// command sequences out on the flash pins. Assumes the flash pins are joined
// outside; data pins are split into in, out and an active-low output enable.
`timescale 1ns/1ps
`default_nettype none
module fbh_host
   import fbh_pkg::*;
#(
   parameter logic [19:0] UNLOCK1_ADDR = 20'h00001,
   parameter logic [15:0] UNLOCK1_DATA = 16'h0011,
   parameter logic [19:0] UNLOCK2_ADDR = 20'h00002,
   parameter logic [15:0] UNLOCK2_DATA = 16'h0022,
   parameter logic [15:0] PROG_CODE    = 16'h0033,
   parameter logic [15:0] ASEL_CODE    = 16'h0044,
   parameter logic [19:0] BANK_MASK    = 20'hf0000
)(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output fbh_pins_s        flash,
   input  wire logic [15:0] dq_in,
   input  wire logic        ready_busy_n,
   output logic             byte_n,
   output logic             reset_n,
   output logic             reset_hv
);
   typedef enum logic [2:0] {M_IDLE, M_ISSUE, M_WAIT, M_POLL, M_PWAIT} fbh_st_e;

   fbh_st_e     state;
   fbh_cmd_e    cmd;
   logic [1:0]  idx;
   logic [19:0] cmd_addr;
   logic [15:0] cmd_wdata;
   logic [15:0] rdata;
   logic [2:0]  cfg;
   logic        done_f, tmo_f, ref_f, mism_f;
   logic        bypass, autosel, tmo_seen;
   logic        rb_s1, rb_s2;
   logic [2:0]  wr_cnt;
   logic        cy_done;
   logic [15:0] cy_rdata;

   // ---------------------------------------------------------------
   // Sequence tables
   // ---------------------------------------------------------------
   function automatic logic [1:0] seq_last(input fbh_cmd_e c);
      case (c)
         FC_PROG:                   seq_last = 2'd3;
         FC_AUTOSEL, FC_BYP_ENTER:  seq_last = 2'd2;
         FC_BYP_PROG, FC_BYP_EXIT:  seq_last = 2'd1;
         default:                   seq_last = 2'd0;
      endcase
   endfunction : seq_last

   function automatic fbh_step_s seq_step(input fbh_cmd_e c, input logic [1:0] i,
                                          input logic [19:0] a, input logic [15:0] d);
      logic [19:0] bank;
      bank = a & BANK_MASK;
      seq_step = '{wr: 1'b1, addr: a, data: CODE_RESET};
      if (c == FC_READ) begin
         seq_step.wr = 1'b0;
      end else if (c == FC_PROG || c == FC_AUTOSEL || c == FC_BYP_ENTER) begin
         case (i)
            2'd0: seq_step = '{wr: 1'b1, addr: UNLOCK1_ADDR, data: UNLOCK1_DATA};
            2'd1: seq_step = '{wr: 1'b1, addr: UNLOCK2_ADDR, data: UNLOCK2_DATA};
            2'd2: seq_step = '{wr: 1'b1, addr: bank | UNLOCK1_ADDR,
                               data: (c == FC_PROG) ? PROG_CODE :
                                     (c == FC_AUTOSEL) ? ASEL_CODE :
                                     CODE_BYP_ENT};
            default: seq_step = '{wr: 1'b1, addr: a, data: d};
         endcase
      end else if (c == FC_BYP_PROG) begin
         seq_step = (i == 2'd0) ? '{wr: 1'b1, addr: bank, data: CODE_BYP_PROG}
                                : '{wr: 1'b1, addr: a, data: d};
      end else if (c == FC_BYP_EXIT) begin
         seq_step = '{wr: 1'b1, addr: bank,
                      data: (i == 2'd0) ? CODE_BYP_EX1 : CODE_BYP_EX2};
      end
   endfunction : seq_step

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   wire        apb_wr    = psel && penable && pwrite;
   wire        ctrl_wr   = apb_wr && (paddr == OFF_CTRL);
   wire        stat_wr   = apb_wr && (paddr == OFF_STATUS);
   fbh_cmd_e   req_cmd;
   assign req_cmd = fbh_cmd_e'(pwdata[2:0]);
   wire        req_byp   = (req_cmd == FC_BYP_PROG) || (req_cmd == FC_BYP_EXIT);
   wire        req_valid = (pwdata[2:0] <= 3'(FC_BYP_EXIT));
   // Bypass accepts only its own two commands, and they exist nowhere else
   wire        legal     = req_valid && (bypass == req_byp) && !cfg[CFG_HWRST];
   wire        accept    = ctrl_wr && (state == M_IDLE) && legal;
   wire        refuse    = ctrl_wr && !accept;
   fbh_step_s  step;
   assign step = seq_step(cmd, idx, cmd_addr, cmd_wdata);
   wire        polling   = (state == M_POLL) || (state == M_PWAIT);
   wire        last_step = (idx == seq_last(cmd));
   wire        is_prog   = (cmd == FC_PROG) || (cmd == FC_BYP_PROG);
   wire        poll_ok   = (cy_rdata[POLL_BIT] == cmd_wdata[POLL_BIT]);
   wire        poll_tmo  = cy_rdata[TMO_BIT];
   wire [15:0] cmp_mask  = cfg[CFG_BYTE] ? 16'h00ff : 16'hffff;
   wire        finish    = cy_done && (state == M_WAIT) && last_step && !is_prog;
   wire        poll_end  = cy_done && (state == M_PWAIT) && poll_ok;
   wire        tmo_hit   = cy_done && (state == M_PWAIT) && !poll_ok && poll_tmo && tmo_seen;
   wire        abort     = cfg[CFG_HWRST] && (state != M_IDLE);
   wire        op_end    = finish || poll_end;
   wire        mism      = poll_end && (((cy_rdata ^ cmd_wdata) & cmp_mask) != 16'h0000);

   fbh_cycle u_cycle (
      .clk   (clk),
      .nrst  (nrst),
      .start ((state == M_ISSUE) || (state == M_POLL)),
      .wr    (polling ? 1'b0 : step.wr),
      .addr  (polling ? cmd_addr : step.addr),
      .wdata (step.data),
      .dq_in (dq_in),
      .pins  (flash),
      .done  (cy_done),
      .rdata (cy_rdata)
   );

   // ---------------------------------------------------------------
   // Command sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state    <= M_IDLE;
         cmd      <= FC_RESET;
         idx      <= 2'd0;
         tmo_seen <= 1'b0;
         cmd_addr <= 20'h00000;
         cmd_wdata <= 16'h0000;
      end else if (abort) begin
         state <= M_IDLE;
      end else begin
         if (state == M_IDLE && psel && penable && pwrite && paddr == OFF_ADDR)
            cmd_addr <= pwdata[19:0];
         if (state == M_IDLE && psel && penable && pwrite && paddr == OFF_WDATA)
            cmd_wdata <= pwdata[15:0];
         case (state)
            M_IDLE: if (accept) begin
               cmd      <= req_cmd;
               idx      <= 2'd0;
               tmo_seen <= 1'b0;
               state    <= M_ISSUE;
            end
            M_ISSUE: state <= M_WAIT;
            M_WAIT: if (cy_done) begin
               if (!last_step) begin
                  idx   <= idx + 2'd1;
                  state <= M_ISSUE;
               end else begin
                  state <= is_prog ? M_POLL : M_IDLE;
               end
            end
            M_POLL: state <= M_PWAIT;
            M_PWAIT: if (cy_done) begin
               if (poll_ok) begin
                  state <= M_IDLE;
               end else if (tmo_hit) begin
                  // Flag confirmed on a second read: bring the bank back
                  cmd   <= FC_RESET;
                  idx   <= 2'd0;
                  state <= M_ISSUE;
               end else begin
                  tmo_seen <= poll_tmo;
                  state    <= M_POLL;
               end
            end
            default: state <= M_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Status, modes and configuration
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      rb_s1 <= ready_busy_n;
      rb_s2 <= rb_s1;
   end

   // Sticky flags: a set in the clearing cycle wins
   always_ff @(posedge clk) begin
      if (!nrst) begin
         done_f  <= 1'b0;
         tmo_f   <= 1'b0;
         ref_f   <= 1'b0;
         mism_f  <= 1'b0;
         bypass  <= 1'b0;
         autosel <= 1'b0;
         cfg     <= CFG_RESET;
         rdata   <= 16'h0000;
      end else begin
         done_f <= op_end || (done_f && !(stat_wr && pwdata[ST_DONE]));
         tmo_f  <= tmo_hit || (tmo_f && !(stat_wr && pwdata[ST_TMO]));
         ref_f  <= refuse || (ref_f && !(stat_wr && pwdata[ST_REF]));
         mism_f <= mism || (mism_f && !(stat_wr && pwdata[ST_MISM]));
         if (apb_wr && paddr == OFF_CFG)
            cfg <= pwdata[2:0];
         if (op_end && (cmd == FC_READ || is_prog))
            rdata <= cy_rdata;
         // Hardware reset during an operation drops every bank mode
         if (abort || (finish && cmd == FC_RESET))
            autosel <= 1'b0;
         else if (finish && cmd == FC_AUTOSEL)
            autosel <= 1'b1;
         if (abort || (finish && cmd == FC_BYP_EXIT))
            bypass <= 1'b0;
         else if (finish && cmd == FC_BYP_ENTER)
            bypass <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // APB read side and pin outputs
   // ---------------------------------------------------------------
   wire [7:0] status = {rb_s2, autosel, bypass, mism_f, ref_f, tmo_f, done_f,
                        (state != M_IDLE)};
   wire       mapped = (paddr == OFF_CTRL) || (paddr == OFF_ADDR) || (paddr == OFF_WDATA) ||
                       (paddr == OFF_STATUS) || (paddr == OFF_RDATA) || (paddr == OFF_CFG);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata  = (paddr == OFF_CTRL)   ? {29'h0, cmd} :
                    (paddr == OFF_ADDR)   ? {12'h000, cmd_addr} :
                    (paddr == OFF_WDATA)  ? {16'h0000, cmd_wdata} :
                    (paddr == OFF_STATUS) ? {24'h000000, status} :
                    (paddr == OFF_RDATA)  ? {16'h0000, rdata} :
                    (paddr == OFF_CFG)    ? {29'h0, cfg} : 32'h00000000;
   assign byte_n   = !cfg[CFG_BYTE];
   assign reset_n  = !cfg[CFG_HWRST];
   assign reset_hv = cfg[CFG_HV];

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst || (state == M_IDLE))
         wr_cnt <= 3'd0;
      else if (cy_done && state == M_WAIT)
         wr_cnt <= wr_cnt + 3'd1;
   end

   a_prog_four: assert property (@(posedge clk) disable iff (!nrst)
      state == M_POLL && cmd == FC_PROG && $past(state) == M_WAIT |-> wr_cnt == 3'd4)
      else $error("program did not issue four writes");
   a_bypass_two: assert property (@(posedge clk) disable iff (!nrst)
      state == M_POLL && cmd == FC_BYP_PROG && $past(state) == M_WAIT |-> wr_cnt == 3'd2)
      else $error("bypass program did not issue two writes");
   a_bypass_refuse: assert property (@(posedge clk) disable iff (!nrst)
      ctrl_wr && bypass && !req_byp |=> ref_f && state == M_IDLE)
      else $error("command accepted in bypass mode");
   a_tmo_reset: assert property (@(posedge clk) disable iff (!nrst)
      tmo_hit && !abort |=> cmd == FC_RESET ##[1:3] (!flash.we_n && flash.dq_out == CODE_RESET))
      else $error("no reset written after timeout flag");
   a_hw_abort: assert property (@(posedge clk) disable iff (!nrst)
      abort |=> state == M_IDLE && !reset_n)
      else $error("hardware reset did not abort the operation");
   a_hv_follow: assert property (@(posedge clk) disable iff (!nrst)
      apb_wr && paddr == OFF_CFG |=> reset_hv == $past(pwdata[CFG_HV]))
      else $error("high-voltage reset level not following config");
   a_reset_quiet: assert property (@(posedge clk)
      !nrst |=> flash.we_n && flash.ce_n && flash.oe_n)
      else $error("strobes active after reset");
   a_busy_refuse: assert property (@(posedge clk) disable iff (!nrst)
      ctrl_wr && state != M_IDLE |=> ref_f && $stable(cmd))
      else $error("command taken while busy");
   a_asel_exit: assert property (@(posedge clk) disable iff (!nrst)
      finish && cmd == FC_RESET |=> !autosel)
      else $error("reset left autoselect mode set");

   c_prog_done:  cover property (@(posedge clk) disable iff (!nrst) poll_end && cmd == FC_PROG);
   c_byp_done:   cover property (@(posedge clk) disable iff (!nrst)
                                 poll_end && cmd == FC_BYP_PROG);
   c_autosel:    cover property (@(posedge clk) disable iff (!nrst)
                                 finish && cmd == FC_AUTOSEL);
   c_timeout:    cover property (@(posedge clk) disable iff (!nrst) tmo_hit);
endmodule : fbh_host
`default_nettype wire

// ===== logic/fbh_pkg.sv
// Shared constants and types of the flash bus host controller.
// Assumes a 200 MHz clock; all pin timings are converted to cycles here.
package fbh_pkg;
   // ---------------------------------------------------------------
   // Clock and pin timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int T_SETUP_NS    = 10;
   localparam int T_WP_NS       = 35;
   localparam int T_WPH_NS      = 30;
   localparam int T_ACC_NS      = 70;
   // Least times round up, never below one cycle
   localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WP_CYC    = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WPH_CYC   = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Two extra cycles cover the data synchroniser
   localparam int ACC_CYC   = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_ADDR   = 8'h04;
   localparam logic [7:0] OFF_WDATA  = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam logic [7:0] OFF_RDATA  = 8'h10;
   localparam logic [7:0] OFF_CFG    = 8'h14;
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_TMO  = 2;
   localparam int ST_REF  = 3;
   localparam int ST_MISM = 4;
   localparam int ST_BYP  = 5;
   localparam int ST_ASEL = 6;
   localparam int ST_RDY  = 7;
   localparam int CFG_BYTE = 0;
   localparam int CFG_HWRST = 1;
   localparam int CFG_HV   = 2;
   localparam logic [2:0] CFG_RESET = 3'h0;

   // ---------------------------------------------------------------
   // Command codes on the flash bus
   // ---------------------------------------------------------------
   localparam logic [15:0] CODE_RESET    = 16'h00f0;
   localparam logic [15:0] CODE_BYP_ENT  = 16'h0020;
   localparam logic [15:0] CODE_BYP_PROG = 16'h00a0;
   localparam logic [15:0] CODE_BYP_EX1  = 16'h0090;
   localparam logic [15:0] CODE_BYP_EX2  = 16'h0000;
   localparam int POLL_BIT = 7;
   localparam int TMO_BIT  = 5;

   typedef enum logic [2:0] {
      FC_RESET, FC_PROG, FC_AUTOSEL, FC_READ, FC_BYP_ENTER, FC_BYP_PROG, FC_BYP_EXIT
   } fbh_cmd_e;

   typedef struct packed {
      logic        ce_n;
      logic        we_n;
      logic        oe_n;
      logic [19:0] addr;
      logic [15:0] dq_out;
      logic        dq_oe_n;
   } fbh_pins_s;

   typedef struct packed {
      logic        wr;
      logic [19:0] addr;
      logic [15:0] data;
   } fbh_step_s;
endpackage : fbh_pkg

// ===== logic/fbh_cycle.sv
// One asynchronous flash bus cycle, write or read, on the controller's clock.
// Assumes the caller holds start inputs stable until done pulses.
`timescale 1ns/1ps
`default_nettype none
module fbh_cycle
   import fbh_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        start,
   input  wire logic        wr,
   input  wire logic [19:0] addr,
   input  wire logic [15:0] wdata,
   input  wire logic [15:0] dq_in,
   output fbh_pins_s        pins,
   output logic             done,
   output logic [15:0]      rdata
);
   typedef enum logic [2:0] {CY_IDLE, CY_SETUP, CY_PULSE, CY_HOLD, CY_READ} fbh_cy_e;
   fbh_cy_e     state;
   logic [7:0]  cnt;
   logic        is_wr;
   logic [15:0] dq_s1;
   logic [15:0] dq_s2;
   wire         last = (cnt == 8'h01);

   // ---------------------------------------------------------------
   // Data pin synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
   end

   // ---------------------------------------------------------------
   // Cycle sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      done <= 1'b0;
      if (!nrst) begin
         state <= CY_IDLE;
         cnt   <= 8'h00;
         is_wr <= 1'b0;
         rdata <= 16'h0000;
         pins  <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 20'h00000,
                    dq_out: 16'h0000, dq_oe_n: 1'b1};
      end else begin
         case (state)
            CY_IDLE: if (start) begin
               is_wr       <= wr;
               pins.addr   <= addr;
               pins.dq_out <= wdata;
               pins.ce_n   <= 1'b0;
               pins.oe_n   <= 1'b1;
               cnt         <= 8'(SETUP_CYC);
               state       <= CY_SETUP;
            end
            CY_SETUP: if (last) begin
               // Strobe falls after chip select, so the address is latched here
               if (is_wr) begin
                  pins.we_n    <= 1'b0;
                  pins.dq_oe_n <= 1'b0;
                  cnt          <= 8'(WP_CYC);
                  state        <= CY_PULSE;
               end else begin
                  pins.oe_n <= 1'b0;
                  cnt       <= 8'(ACC_CYC);
                  state     <= CY_READ;
               end
            end else begin
               cnt <= cnt - 8'h01;
            end
            CY_PULSE: if (last) begin
               // Strobe rises first; data held through the hold time
               pins.we_n <= 1'b1;
               cnt       <= 8'(WPH_CYC);
               state     <= CY_HOLD;
            end else begin
               cnt <= cnt - 8'h01;
            end
            CY_HOLD: if (last) begin
               pins.ce_n    <= 1'b1;
               pins.dq_oe_n <= 1'b1;
               done         <= 1'b1;
               state        <= CY_IDLE;
            end else begin
               cnt <= cnt - 8'h01;
            end
            CY_READ: if (last) begin
               rdata     <= dq_s2;
               pins.oe_n <= 1'b1;
               pins.ce_n <= 1'b1;
               done      <= 1'b1;
               state     <= CY_IDLE;
            end else begin
               cnt <= cnt - 8'h01;
            end
            default: state <= CY_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_write_gating: assert property (@(posedge clk) disable iff (!nrst)
      !pins.we_n |-> !pins.ce_n && pins.oe_n && !pins.dq_oe_n)
      else $error("write strobe low without chip select or with output enable");
   a_addr_stable: assert property (@(posedge clk) disable iff (!nrst)
      !pins.we_n && $past(!pins.we_n) |-> $stable(pins.addr))
      else $error("address moved during write strobe");
   a_data_hold: assert property (@(posedge clk) disable iff (!nrst)
      $rose(pins.we_n) |-> $stable(pins.dq_out) && !pins.dq_oe_n && !pins.ce_n)
      else $error("data or chip select released with the write strobe");
   a_pulse_width: assert property (@(posedge clk) disable iff (!nrst)
      $fell(pins.we_n) |-> !pins.we_n [*7])
      else $error("write strobe pulse too short");
endmodule : fbh_cycle
`default_nettype wire

// ===== bench/fbh_flash_model.sv
// Behavioural two-bank flash, seen only at its pins.
// Assumes one host; embedded program ends at once, so busy never shows.
`timescale 1ns/1ps
`default_nettype none
module fbh_flash_model
   import fbh_pkg::*;
#(
   parameter logic [15:0] MAKER = 16'h005a, // Arbitrary value
   parameter logic [15:0] PART  = 16'h003c  // Arbitrary value
)(
   input  wire fbh_pins_s   p,
   input  wire logic        rst_n,
   input  wire logic        lko,
   output logic [15:0]      dq
);
   // ----
   // Command decoder
   // ----
   logic [15:0] mem [int];
   logic [15:0] ed, v;
   logic [19:0] al;
   int          st = 0;
   logic        pend = 0, asel = 0, byp = 0, ex = 0, err = 0;
   function automatic logic [15:0] rd(input logic [19:0] a);
      return mem.exists(a) ? mem[a] : 16'hffff;
   endfunction : rd
   task automatic wr(input logic [19:0] a, input logic [15:0] d);
      if (pend) begin
         mem[a] = rd(a) & d;
         err = mem[a][7] != d[7];
         ed = d;
         pend = 0;
      end else if (d == 16'h00f0 && !byp) begin
         st = 0;
         asel = 0;
         err = 0;
      end else if (byp) begin
         pend = d == 16'h00a0;
         if (ex && d == 16'h0000) byp = 0;
         ex = d == 16'h0090;
      end else if (st == 2) begin
         pend = d == 16'h0033;
         asel = d == 16'h0044;
         byp = d == 16'h0020;
         st = 0;
      end else if (d == (st ? 16'h0022 : 16'h0011) && a[11:0] == st + 1) st++;
      else st = 0;
   endtask : wr
   always @(negedge p.we_n) if (!p.ce_n) al = p.addr;
   always @(posedge p.we_n) if (!p.ce_n && p.oe_n && rst_n && !lko) wr(al, p.dq_out);
   // Lockout and hardware reset both drop back to array reads
   always @(negedge rst_n or posedge lko) begin
      st = 0;
      {pend, asel, byp, ex, err} = 5'h00;
   end
   // Released pins show the inverse, never a stale value
   always @* begin
      if (err) v = {8'h00, ~ed[7], 2'b01, 5'h00};
      else if (asel) v = p.addr[7:0] == 8'h00 ? MAKER : PART;
      else v = rd(p.addr);
      dq = (p.ce_n || p.oe_n) ? ~v : v;
   end
endmodule : fbh_flash_model
`default_nettype wire

// ===== bench/fbh_host_tb.sv
// Self-checking bench: APB orders in, flash model on the pins.
// Assumes the model's codes match the host's default parameters.
`timescale 1ns/1ps
`default_nettype none
module fbh_host_tb
   import fbh_pkg::*;
;
   // ----
   // Harness
   // ----
   logic        clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, lko = 0, rb = 1;
   logic        pready, pslverr, byte_n, reset_n, reset_hv, se;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, st, seed = 32'h0000a02e;
   logic [15:0] dq, x;
   fbh_pins_s   flash;
   logic [15:0] ref_mem [int];
   int          fails = 0, checks_done = 0, n, k;
   fbh_host dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .flash(flash), .dq_in(dq), .ready_busy_n(rb), .byte_n(byte_n), .reset_n(reset_n),
      .reset_hv(reset_hv));
   fbh_flash_model fm (.p(flash), .rst_n(reset_n), .lko(lko), .dq(dq));
   initial forever #2.5 clk = ~clk;
   function automatic logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction : rnd
   task automatic close_out();
      if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   task automatic chk(input string s, input logic [31:0] v, input logic [31:0] e);
      checks_done++;
      if (v !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", s, e, v);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      for (n = 0; n < 9 && pready !== 1'b1; n++) @(posedge clk);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      if (n == 9) begin
         fails++;
         close_out();
      end
   endtask : apb
   task automatic op(input logic [2:0] c, input logic [19:0] ad, input logic [15:0] wd);
      x = rnd();
      rb <= x[0];
      apb(1'b1, OFF_ADDR, {12'h000, ad});
      apb(1'b1, OFF_WDATA, {16'h0000, wd});
      apb(1'b1, OFF_STATUS, 32'h0000001e);
      apb(1'b1, OFF_CTRL, {29'h0, c});
      for (k = 0; k < 3000; k++) begin
         apb(1'b0, OFF_STATUS, 32'h0);
         if (rd[ST_BUSY] === 1'b0) break;
      end
      st = rd;
      if (k == 3000) begin
         fails++;
         close_out();
      end
      chk("ready", st[ST_RDY], rb);
   endtask : op
   // Program, then read back after a normal program only; a 1 never returns once cleared
   task automatic prog(input logic [2:0] c, input logic [19:0] ad, input logic [15:0] wd);
      ref_mem[ad] = (ref_mem.exists(ad) ? ref_mem[ad] : 16'hffff) & wd;
      op(c, ad, wd);
      chk("timeout", st[ST_TMO], ref_mem[ad][7] != wd[7]);
      if (ref_mem[ad][7] == wd[7]) chk("mismatch", st[ST_MISM], ref_mem[ad] != wd);
      if (c == 3'h1) begin
         op(3'h3, ad, 16'h0);
         apb(1'b0, OFF_RDATA, 32'h0);
         chk("rdata", rd, {16'h0, ref_mem[ad]});
      end
   endtask : prog
   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      chk("idle pins", {flash.ce_n, flash.we_n, flash.oe_n, flash.dq_oe_n}, 32'hf);
      apb(1'b0, 8'h40, 32'h0);
      chk("slverr", se, 32'h1);
      for (int i = 0; i < 8; i++) begin
         x = rnd();
         prog(3'h1, 20'h10100 + x[1:0], rnd());
      end
      // Writes lost under lockout: erased cell never matches, timeout path runs
      lko <= 1'b1;
      op(3'h1, 20'h10300, 16'h0000);
      chk("lockout tmo", st[ST_TMO], 32'h1);
      lko <= 1'b0;
      op(3'h3, 20'h10300, 16'h0);
      apb(1'b0, OFF_RDATA, 32'h0);
      chk("lockout data", rd, 32'h0000ffff);
      op(3'h2, 20'h80000, 16'h0);
      chk("asel", st[ST_ASEL], 32'h1);
      for (int i = 0; i < 3; i++) begin
         op(3'h3, 20'h80000 + i[0], 16'h0);
         apb(1'b0, OFF_RDATA, 32'h0);
         chk("idcode", rd, i[0] ? 32'h0000003c : 32'h0000005a);
      end
      op(3'h0, 20'h80000, 16'h0);
      chk("asel off", st[ST_ASEL], 32'h0);
      op(3'h5, 20'h10200, 16'h1234);
      chk("refused", st[ST_REF], 32'h1);
      op(3'h4, 20'h10000, 16'h0);
      chk("bypass", st[ST_BYP], 32'h1);
      op(3'h0, 20'h10000, 16'h0);
      chk("refused", st[ST_REF], 32'h1);
      prog(3'h5, 20'h10200, rnd());
      op(3'h6, 20'h10000, 16'h0);
      chk("bypass off", st[ST_BYP], 32'h0);
      // Second order while busy is refused, then hardware reset aborts
      apb(1'b1, OFF_STATUS, 32'h0000001e);
      apb(1'b1, OFF_CTRL, 32'h1);
      apb(1'b1, OFF_CTRL, 32'h3);
      apb(1'b1, OFF_CFG, 32'h2);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk("abort", rd[3:0], 32'h8);
      apb(1'b1, OFF_CFG, 32'h7);
      @(negedge clk);
      chk("cfg pins", {byte_n, reset_n, reset_hv}, 32'h1);
      @(posedge clk);
      apb(1'b0, OFF_CFG, 32'h0);
      chk("cfg", rd, 32'h7);
      apb(1'b1, OFF_CFG, 32'h0);
      close_out();
   end
endmodule : fbh_host_tb
`default_nettype wire
